/* design/rtc_cmos_bank_access.sv */
// Purpose: time of day clock with two cmos banks behind index/data ports
// Assumes: core_clk_i 50 MHz; ports reached by a host bus and a microcontroller
// Notes: apb holds configuration; the 32 kHz reference is synchronised here
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module rtc_cmos_bank_access
    import rtc_cmos_pkg::*;
#(
    parameter int REF_DIV = REF_CLK_HZ // reference ticks per second
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // i/o port bus (host or microcontroller, already arbitrated)
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic io_hit_o,
    // reference and interrupts
    input wire logic ref_32k_i,
    output logic clock_irq_pin_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // storage and configuration state
    // ------------------------------------------------------------
    logic [7:0] first_cmos_bank [0:126]; // first bank bytes below shared one
    logic [7:0] second_cmos_bank [0:126]; // second bank bytes below shared one
    logic [7:0] shared_ctrl; // byte seen at the top of either bank
    logic [7:0] bank_activate, next_bank_activate;
    logic [7:0] first_base_hi, next_first_base_hi;
    logic [7:0] first_base_lo, next_first_base_lo;
    logic [7:0] second_base_hi, next_second_base_hi;
    logic [7:0] second_base_lo, next_second_base_lo;
    logic [6:0] first_index, second_index; // index latches
    logic [2:0] int_status, next_int_status; // sticky events
    logic [2:0] int_mask, next_int_mask;
    logic [7:0] ctrl_c; // hardware flags in cmos view
    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic apb_wr, apb_rd;
    assign apb_wr = psel_i && penable_i && pwrite_i && pready_o; // lands on the answering edge
    assign apb_rd = psel_i && penable_i && !pwrite_i;
    // configuration next values
    always_comb begin
        next_bank_activate = bank_activate;
        next_first_base_hi = first_base_hi;
        next_first_base_lo = first_base_lo;
        next_second_base_hi = second_base_hi;
        next_second_base_lo = second_base_lo;
        next_int_mask = int_mask;
        if (apb_wr) begin
            case (paddr_i[11:2])
                BANK_ACTIVATE_OFS: next_bank_activate = {6'h00, pwdata_i[1:0]};
                FIRST_BASE_HI_OFS: next_first_base_hi = pwdata_i[7:0];
                FIRST_BASE_LO_OFS: next_first_base_lo = {pwdata_i[7:1], 1'b0};
                SECOND_BASE_HI_OFS: next_second_base_hi = pwdata_i[7:0];
                SECOND_BASE_LO_OFS: next_second_base_lo = {pwdata_i[7:1], 1'b0};
                INT_MASK_OFS: next_int_mask = pwdata_i[2:0];
                default: ;
            endcase
        end
    end
    // configuration registers; synchronous reset covers hard/soft/power-on
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            bank_activate <= BANK_ACTIVATE_RST;
            first_base_hi <= BASE_HI_RST;
            first_base_lo <= FIRST_BASE_LO_RST;
            second_base_hi <= BASE_HI_RST;
            second_base_lo <= SECOND_BASE_LO_RST;
            int_mask <= 3'h0;
        end else begin
            bank_activate <= next_bank_activate;
            first_base_hi <= next_first_base_hi;
            first_base_lo <= next_first_base_lo;
            second_base_hi <= next_second_base_hi;
            second_base_lo <= next_second_base_lo;
            int_mask <= next_int_mask;
        end
    end
    // ------------------------------------------------------------
    // port decode: index at base, data at base+1
    // ------------------------------------------------------------
    logic [15:0] first_base, second_base;
    logic first_hit, second_hit, port_is_data;
    assign first_base = {first_base_hi, first_base_lo};
    assign second_base = {second_base_hi, second_base_lo};
    assign first_hit = bank_activate[ACT_FIRST_BIT] && (io_addr_i[15:1] == first_base[15:1]);
    assign second_hit = bank_activate[ACT_SECOND_BIT] && (io_addr_i[15:1] == second_base[15:1]);
    assign port_is_data = io_addr_i[0];
    // byte selected by each index; top location goes to shared control
    logic [7:0] first_byte, second_byte;
    always_comb begin
        first_byte = (first_index == LOC_SHARED) ? shared_ctrl : first_cmos_bank[first_index];
        if (first_index == LOC_CTRL_C) begin
            first_byte = ctrl_c;
        end
        second_byte = (second_index == LOC_SHARED) ? shared_ctrl : second_cmos_bank[second_index];
    end
    // ------------------------------------------------------------
    // reference sync and one-second divider
    // ------------------------------------------------------------
    logic ref_meta, ref_sync, ref_last;
    logic [15:0] ref_count, next_ref_count;
    logic ref_tick, sec_tick;
    assign ref_tick = ref_sync && !ref_last; // rising reference edge
    always_comb begin
        next_ref_count = ref_count;
        sec_tick = 1'b0;
        if (ref_tick) begin
            if (ref_count == 16'(REF_DIV - 1)) begin
                next_ref_count = 16'h0000;
                sec_tick = 1'b1;
            end else begin
                next_ref_count = ref_count + 16'h0001;
            end
        end
    end
    // periodic rate: tap of the reference count chosen by control A
    logic [3:0] rate_sel;
    logic periodic_tick;
    assign rate_sel = first_cmos_bank[LOC_CTRL_A][3:0];
    assign periodic_tick = ref_tick && (rate_sel != 4'h0) &&
        (next_ref_count[rate_sel - 4'h1 +: 1] && !ref_count[rate_sel - 4'h1 +: 1]);
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            ref_meta <= 1'b0;
            ref_sync <= 1'b0;
            ref_last <= 1'b0;
            ref_count <= 16'h0000;
        end else begin
            ref_meta <= ref_32k_i;
            ref_sync <= ref_meta;
            ref_last <= ref_sync;
            ref_count <= next_ref_count;
        end
    end
    // ------------------------------------------------------------
    // calendar arithmetic in binary or bcd
    // ------------------------------------------------------------
    logic binary_mode;
    assign binary_mode = first_cmos_bank[LOC_CTRL_B][CTRL_B_BINARY_BIT];
    // step a field; wraps to lo past hi, honouring the selected form
    function automatic logic [7:0] step(input logic [7:0] v, input logic [7:0] lo,
        input logic [7:0] hi, input logic bin);
        logic [7:0] r;
        r = 8'h00;
        if (v == hi) begin
            r = lo;
        end else if (bin || v[3:0] != 4'h9) begin
            r = v + 8'h01;
        end else begin
            r = {v[7:4] + 4'h1, 4'h0};
        end
        return r;
    endfunction
    logic [7:0] n_sec, n_min, n_hour, n_dow, n_date, n_month, n_year, n_cent, last_day;
    logic c_min, c_hour, c_day, c_month, c_year;
    always_comb begin
        last_day = binary_mode ? 8'h1E : 8'h30; // 30-day months kept simple
        c_min = first_cmos_bank[LOC_SEC] == (binary_mode ? 8'h3B : 8'h59);
        c_hour = c_min && first_cmos_bank[LOC_MIN] == (binary_mode ? 8'h3B : 8'h59);
        c_day = c_hour && first_cmos_bank[LOC_HOUR] == (binary_mode ? 8'h17 : 8'h23);
        c_month = c_day && first_cmos_bank[LOC_DATE] == last_day;
        c_year = c_month && first_cmos_bank[LOC_MONTH] == (binary_mode ? 8'h0C : 8'h12);
        n_sec = step(first_cmos_bank[LOC_SEC], 8'h00, binary_mode ? 8'h3B : 8'h59, binary_mode);
        n_min = step(first_cmos_bank[LOC_MIN], 8'h00, binary_mode ? 8'h3B : 8'h59, binary_mode);
        n_hour = step(first_cmos_bank[LOC_HOUR], 8'h00, binary_mode ? 8'h17 : 8'h23, binary_mode);
        n_dow = step(first_cmos_bank[LOC_DOW], 8'h01, 8'h07, binary_mode);
        n_date = step(first_cmos_bank[LOC_DATE], 8'h01, last_day, binary_mode);
        n_month = step(first_cmos_bank[LOC_MONTH], 8'h01, binary_mode ? 8'h0C : 8'h12, binary_mode);
        n_year = step(first_cmos_bank[LOC_YEAR], 8'h00, binary_mode ? 8'h63 : 8'h99, binary_mode);
        n_cent = step(first_cmos_bank[LOC_CENTURY], 8'h00, binary_mode ? 8'h63 : 8'h99, binary_mode);
    end
    // alarm compares after the second has been updated; date alarm 0 = don't care
    logic alarm_hit;
    assign alarm_hit = sec_tick && n_sec == first_cmos_bank[LOC_SEC_ALM] &&
        (c_min ? n_min : first_cmos_bank[LOC_MIN]) == first_cmos_bank[LOC_MIN_ALM] &&
        (c_hour ? n_hour : first_cmos_bank[LOC_HOUR]) == first_cmos_bank[LOC_HOUR_ALM] &&
        (first_cmos_bank[LOC_DATE_ALM] == 8'h00 ||
        (c_day ? n_date : first_cmos_bank[LOC_DATE]) == first_cmos_bank[LOC_DATE_ALM]);
    // ------------------------------------------------------------
    // cmos array, index latches, clock counting
    // ------------------------------------------------------------
    // one write port per bank; a port write and a tick can hit the same clock byte
    // in one cycle, and then the port write wins over the tick
    logic wr_first_data, wr_second_data, rd_first_data;
    assign wr_first_data = io_wr_i && first_hit && port_is_data;
    assign wr_second_data = io_wr_i && second_hit && port_is_data;
    assign rd_first_data = io_rd_i && first_hit && port_is_data;
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            first_index <= 7'h00;
            second_index <= 7'h00;
            shared_ctrl <= 8'h00;
        end else begin
            if (io_wr_i && first_hit && !port_is_data) begin
                first_index <= io_wdata_i[6:0];
            end
            if (io_wr_i && second_hit && !port_is_data) begin
                second_index <= io_wdata_i[6:0];
            end
            if ((wr_first_data && first_index == LOC_SHARED) ||
                (wr_second_data && second_index == LOC_SHARED)) begin
                shared_ctrl <= io_wdata_i;
            end
        end
    end
    // battery-backed bytes are not cleared by reset
    always_ff @(posedge core_clk_i) begin
        if (sec_tick) begin
            first_cmos_bank[LOC_SEC] <= n_sec;
            if (c_min) first_cmos_bank[LOC_MIN] <= n_min;
            if (c_hour) first_cmos_bank[LOC_HOUR] <= n_hour;
            if (c_day) first_cmos_bank[LOC_DOW] <= n_dow;
            if (c_day) first_cmos_bank[LOC_DATE] <= n_date;
            if (c_month) first_cmos_bank[LOC_MONTH] <= n_month;
            if (c_year) first_cmos_bank[LOC_YEAR] <= n_year;
            if (c_year && n_year == 8'h00) first_cmos_bank[LOC_CENTURY] <= n_cent;
        end
        if (wr_first_data && first_index != LOC_SHARED) begin
            first_cmos_bank[first_index] <= io_wdata_i;
        end
        if (wr_second_data && second_index != LOC_SHARED) begin
            second_cmos_bank[second_index] <= io_wdata_i;
        end
    end
    // ------------------------------------------------------------
    // interrupt flags: set wins over clear
    // ------------------------------------------------------------
    logic [2:0] events;
    logic [7:0] next_ctrl_c;
    assign events = {sec_tick, periodic_tick, alarm_hit};
    always_comb begin
        next_int_status = int_status;
        if (apb_wr && paddr_i[11:2] == INT_STATUS_OFS) begin
            next_int_status = int_status & ~pwdata_i[2:0];
        end
        next_int_status = next_int_status | events;
        // control C: read clears, then new events set again
        next_ctrl_c = ctrl_c;
        if (rd_first_data && first_index == LOC_CTRL_C) begin
            next_ctrl_c = 8'h00;
        end
        next_ctrl_c[6:4] = next_ctrl_c[6:4] | {periodic_tick, alarm_hit, sec_tick};
        next_ctrl_c[7] = |(next_ctrl_c[6:4] & first_cmos_bank[LOC_CTRL_B][6:4]);
    end
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            int_status <= 3'h0;
            ctrl_c <= 8'h00;
            clock_irq_pin_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            int_status <= next_int_status;
            ctrl_c <= next_ctrl_c;
            clock_irq_pin_o <= next_ctrl_c[7];
            irq_o <= |(next_int_status & next_int_mask);
        end
    end
    // ------------------------------------------------------------
    // read paths
    // ------------------------------------------------------------
    logic [31:0] next_prdata;
    logic next_pslverr;
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        case (paddr_i[11:2])
            BANK_ACTIVATE_OFS: next_prdata = {24'h000000, bank_activate};
            FIRST_BASE_HI_OFS: next_prdata = {24'h000000, first_base_hi};
            FIRST_BASE_LO_OFS: next_prdata = {24'h000000, first_base_lo};
            SECOND_BASE_HI_OFS: next_prdata = {24'h000000, second_base_hi};
            SECOND_BASE_LO_OFS: next_prdata = {24'h000000, second_base_lo};
            INT_STATUS_OFS: next_prdata = {29'h0, int_status};
            INT_MASK_OFS: next_prdata = {29'h0, int_mask};
            INDEX_SHADOW_OFS: next_prdata = {25'h0, first_index};
            default: next_pslverr = 1'b1;
        endcase
    end
    // apb answers with one wait state: pready rises in the second access cycle
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            io_rdata_o <= 8'h00;
            io_hit_o <= 1'b0;
        end else begin
            pready_o <= psel_i && penable_i && !pready_o;
            pslverr_o <= psel_i && penable_i && !pready_o && next_pslverr;
            if (apb_rd && !pready_o) prdata_o <= next_prdata;
            io_hit_o <= io_rd_i && (first_hit || second_hit);
            if (io_rd_i && first_hit) begin
                io_rdata_o <= port_is_data ? first_byte : {1'b0, first_index};
            end else if (io_rd_i && second_hit) begin
                io_rdata_o <= port_is_data ? second_byte : {1'b0, second_index};
            end
        end
    end
endmodule

/* design/rtc_cmos_pkg.sv */
// Purpose: constants shared by the clock / cmos bank block
// Assumes: apb register window, 32-bit words, 50 MHz core clock
// Notes: offsets are word indices, apb byte address four times
package rtc_cmos_pkg;
    // ------------------------------------------------------------
    // apb register offsets
    // ------------------------------------------------------------
    localparam logic [9:0] BANK_ACTIVATE_OFS = 10'h030; // activation byte
    localparam logic [9:0] FIRST_BASE_HI_OFS = 10'h060; // first bank base, high
    localparam logic [9:0] FIRST_BASE_LO_OFS = 10'h061; // first bank base, low
    localparam logic [9:0] SECOND_BASE_HI_OFS = 10'h062; // second bank base, high
    localparam logic [9:0] SECOND_BASE_LO_OFS = 10'h063; // second bank base, low
    localparam logic [9:0] INT_STATUS_OFS = 10'h040; // sticky events, write one clears
    localparam logic [9:0] INT_MASK_OFS = 10'h041; // interrupt enables
    localparam logic [9:0] INDEX_SHADOW_OFS = 10'h042; // last first-bank index
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] BANK_ACTIVATE_RST = 8'h00;
    localparam logic [7:0] BASE_HI_RST = 8'h00;
    localparam logic [7:0] FIRST_BASE_LO_RST = 8'h70;
    localparam logic [7:0] SECOND_BASE_LO_RST = 8'h74;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ACT_FIRST_BIT = 0; // enables first bank decode
    localparam int ACT_SECOND_BIT = 1; // enables second bank decode
    // cmos byte locations in the first bank
    localparam logic [6:0] LOC_SEC = 7'h00;
    localparam logic [6:0] LOC_SEC_ALM = 7'h01;
    localparam logic [6:0] LOC_MIN = 7'h02;
    localparam logic [6:0] LOC_MIN_ALM = 7'h03;
    localparam logic [6:0] LOC_HOUR = 7'h04;
    localparam logic [6:0] LOC_HOUR_ALM = 7'h05;
    localparam logic [6:0] LOC_DOW = 7'h06;
    localparam logic [6:0] LOC_DATE = 7'h07;
    localparam logic [6:0] LOC_MONTH = 7'h08;
    localparam logic [6:0] LOC_YEAR = 7'h09;
    localparam logic [6:0] LOC_CTRL_A = 7'h0A; // periodic rate select, low nibble
    localparam logic [6:0] LOC_CTRL_B = 7'h0B; // bit2: binary mode
    localparam logic [6:0] LOC_CTRL_C = 7'h0C; // flags, cleared on read
    localparam logic [6:0] LOC_CTRL_D = 7'h0D; // valid ram
    localparam logic [6:0] LOC_DATE_ALM = 7'h0E; // day-of-month alarm
    localparam logic [6:0] LOC_CENTURY = 7'h0F;
    localparam logic [6:0] LOC_SHARED = 7'h7F; // shared control in both banks
    localparam int CTRL_B_BINARY_BIT = 2;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int REF_CLK_HZ = 32768; // 32 kHz reference
endpackage

/* verification/rtc_cmos_bank_access_assertions.sv */
// Purpose: port-level checks of the clock / cmos bank block
// Assumes: one core clock, synchronous active-low reset
// Notes: attached by the bind at the foot of this file
`timescale 1ns/100ps
module rtc_cmos_bank_access_assertions (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // apb side
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // port side and interrupts
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic io_hit_o,
    input wire logic clock_irq_pin_o,
    input wire logic irq_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // ----
    // apb timing: one wait state, one-cycle answer
    // ----
    sequence s_access;
        psel_i && penable_i && !pready_o;
    endsequence
    property p_ready_wait;
        s_access |=> pready_o;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("pready late");
    property p_ready_pulse;
        pready_o |=> !pready_o;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    property p_err_with_ready;
        pslverr_o |-> pready_o;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
    // read data only moves on a read answer
    property p_prdata_hold;
        $changed(prdata_o) |-> pready_o && !pwrite_i;
    endproperty
    a_prdata_hold: assert property (p_prdata_hold) else $error("prdata moved");
    // ----
    // port side: hits need a read strobe
    // ----
    property p_hit_cause;
        io_hit_o |-> $past(io_rd_i);
    endproperty
    a_hit_cause: assert property (p_hit_cause) else $error("port hit without read");
    property p_rdata_hold;
        $changed(io_rdata_o) |-> io_hit_o;
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("io data moved");
    // ----
    // interrupts fall only after a software access
    // ----
    property p_irq_fall;
        $fell(irq_o) |-> $past(psel_i && pwrite_i, 1) || $past(psel_i && pwrite_i, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
    property p_pin_fall;
        $fell(clock_irq_pin_o) |-> $past(io_rd_i || io_wr_i, 1) || $past(io_rd_i || io_wr_i, 2)
            || $past(io_rd_i || io_wr_i, 3);
    endproperty
    a_pin_fall: assert property (p_pin_fall) else $error("pin fell alone");
    // reset quiets pready, both interrupt lines and the port hit; not disabled by reset on purpose
    property p_reset_quiet;
        disable iff (1'b0) !resetn_i |=> !pready_o && !irq_o && !clock_irq_pin_o && !io_hit_o;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("active in reset");
endmodule
bind rtc_cmos_bank_access rtc_cmos_bank_access_assertions u_chk (.core_clk_i, .resetn_i, .psel_i, .penable_i,
    .pwrite_i, .prdata_o, .pready_o, .pslverr_o, .io_wr_i, .io_rd_i, .io_rdata_o, .io_hit_o,
    .clock_irq_pin_o, .irq_o);

/* verification/rtc_port_host.sv */
// Purpose: model of the port-side accessor, host or microcontroller
// Assumes: one strobe cycle per access, answer one cycle later
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/100ps
module rtc_port_host (
    // clock
    input wire logic clk_i,
    // port bus towards the block
    output logic io_wr_o,
    output logic io_rd_o,
    output logic [15:0] io_addr_o,
    output logic [7:0] io_wdata_o,
    input wire logic [7:0] io_rdata_i,
    input wire logic io_hit_i
);
    // idle bus at time zero
    initial begin
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_addr_o = 16'h0000;
        io_wdata_o = 8'h00;
    end
    // one strobe, then release with strobes low and address and data inverted
    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        io_wr_o <= wr;
        io_rd_o <= !wr;
        io_addr_o <= a;
        io_wdata_o <= d;
        @(posedge clk_i);
        io_wr_o <= 1'b0;
        io_rd_o <= 1'b0;
        io_addr_o <= ~a;
        io_wdata_o <= ~d;
    endtask
    // callers write the index port before the data port
    task automatic port_wr(input logic [15:0] a, input logic [7:0] d);
        access(1'b1, a, d);
    endtask
    // answer is sampled one cycle after the strobe was taken
    task automatic port_rd(input logic [15:0] a, output logic [7:0] d, output logic h);
        access(1'b0, a, 8'h00);
        @(posedge clk_i);
        d = io_rdata_i;
        h = io_hit_i;
    endtask
endmodule

/* verification/rtc_cmos_bank_access_tb_top.sv */
// Purpose: directed bench for the clock / cmos bank block
// Assumes: REF_DIV shortened to 4 reference ticks per second
// Notes: reference toggles only inside the timekeeping scenario
`timescale 1ns/100ps
module rtc_cmos_bank_access_tb_top
    import rtc_cmos_pkg::*;
;
    // ----
    // signals
    // ----
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, ref_32k, io_wr, io_rd, io_hit, pin_irq, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata;
    int error_cnt = 0;
    int cmp_count = 0;
    rtc_cmos_bank_access #(.REF_DIV(4)) u_dut (.core_clk_i(clk), .resetn_i(resetn), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_addr_i(io_addr),
        .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .io_hit_o(io_hit), .ref_32k_i(ref_32k),
        .clock_irq_pin_o(pin_irq), .irq_o(irq));
    rtc_port_host u_host (.clk_i(clk), .io_wr_o(io_wr), .io_rd_o(io_rd), .io_addr_o(io_addr),
        .io_wdata_o(io_wdata), .io_rdata_i(io_rdata), .io_hit_i(io_hit));
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ----
    // checking and closing
    // ----
    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // apb transfer by word index; bounded wait for pready
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d, output logic [32:0] r);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {a, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            error_cnt++;
            end_of_test();
        end
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic apb_wr(input logic [9:0] a, input logic [31:0] d);
        logic [32:0] r;
        apb(1'b1, a, d, r);
    endtask
    // read with expected {pslverr, data}
    task automatic apb_chk(input string what, input logic [9:0] a, input logic [32:0] exp);
        logic [32:0] r;
        apb(1'b0, a, 32'h0, r);
        check(what, {7'h0, r}, {7'h0, exp});
    endtask
    // port read with expected data and hit
    task automatic port_chk(input string what, input logic [15:0] a, input logic [7:0] eb, input logic eh);
        logic [7:0] b;
        logic h;
        u_host.port_rd(a, b, h);
        check(what, {31'h0, h, b}, {31'h0, eh, eb});
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        {psel, penable, pwrite, ref_32k} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        resetn = 1'b0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        apb_chk("activate", BANK_ACTIVATE_OFS, 33'h0);
        apb_chk("base_hi_first", FIRST_BASE_HI_OFS, 33'h0);
        apb_chk("base_lo_first", FIRST_BASE_LO_OFS, 33'h70);
        apb_chk("base_lo_second", SECOND_BASE_LO_OFS, 33'h74);
        apb_chk("unmapped", 10'h080, 33'h100000000);
        // both banks off: no answer at the first bank's default ports
        u_host.port_wr(16'h0070, 8'h20);
        port_chk("first_off", 16'h0071, 8'h00, 1'b0);
        apb_wr(BANK_ACTIVATE_OFS, 32'h1);
        u_host.port_wr(16'h0070, 8'h20);
        u_host.port_wr(16'h0071, 8'h5A);
        port_chk("first_byte", 16'h0071, 8'h5A, 1'b1);
        apb_chk("index_shadow", INDEX_SHADOW_OFS, 33'h20);
        port_chk("second_off", 16'h0075, 8'h5A, 1'b0);
        // both on: same index, separate storage; last byte shared
        apb_wr(BANK_ACTIVATE_OFS, 32'h3);
        u_host.port_wr(16'h0074, 8'h20);
        u_host.port_wr(16'h0075, 8'hA5);
        port_chk("second_byte", 16'h0075, 8'hA5, 1'b1);
        u_host.port_wr(16'h0070, 8'h20);
        port_chk("first_kept", 16'h0071, 8'h5A, 1'b1);
        u_host.port_wr(16'h0070, 8'h7F);
        u_host.port_wr(16'h0071, 8'h3C);
        u_host.port_wr(16'h0074, 8'h7F);
        port_chk("shared_byte", 16'h0075, 8'h3C, 1'b1);
        // relocate the first bank; low address bit is forced to zero
        apb_wr(FIRST_BASE_LO_OFS, 32'h81);
        apb_chk("base_lo_moved", FIRST_BASE_LO_OFS, 33'h80);
        u_host.port_wr(16'h0080, 8'h20);
        port_chk("moved_byte", 16'h0081, 8'h5A, 1'b1);
        // binary seconds from 9, periodic rate 1, seconds alarm 0 never met
        u_host.port_wr(16'h0080, {1'b0, LOC_CTRL_A});
        u_host.port_wr(16'h0081, 8'h01);
        u_host.port_wr(16'h0080, {1'b0, LOC_SEC_ALM});
        u_host.port_wr(16'h0081, 8'h00);
        u_host.port_wr(16'h0080, {1'b0, LOC_CTRL_B});
        u_host.port_wr(16'h0081, 8'h14);
        u_host.port_wr(16'h0080, {1'b0, LOC_SEC});
        u_host.port_wr(16'h0081, 8'h09);
        apb_wr(INT_STATUS_OFS, 32'h7);
        apb_wr(INT_MASK_OFS, 32'h4);
        for (int i = 0; i < 16; i++) begin
            repeat (4) @(posedge clk);
            ref_32k <= ~ref_32k;
        end
        repeat (8) @(posedge clk);
        port_chk("seconds", 16'h0081, 8'h0B, 1'b1);
        check("irq_line", {39'h0, irq}, 40'h1);
        check("clock_pin", {39'h0, pin_irq}, 40'h1);
        apb_wr(INT_MASK_OFS, 32'h0);
        repeat (3) @(posedge clk);
        check("irq_masked", {39'h0, irq}, 40'h0);
        apb_chk("status_sticky", INT_STATUS_OFS, 33'h6);
        apb_wr(INT_STATUS_OFS, 32'h7);
        apb_chk("status_cleared", INT_STATUS_OFS, 33'h0);
        u_host.port_wr(16'h0080, {1'b0, LOC_CTRL_C});
        port_chk("flags_read", 16'h0081, 8'hD0, 1'b1);
        repeat (3) @(posedge clk);
        check("clock_pin_off", {39'h0, pin_irq}, 40'h0);
        end_of_test();
    end
endmodule
